// ### core/ocd_pkg.sv
// constants and types for the oscillator configuration word decoder
// ===========================================================================
package ocd_pkg;

  // ==========================================================================
  // field positions of the oscillator selection word
  localparam int SWITCH_BIT    = 15;
  localparam int MONITOR_BIT   = 14;
  localparam int SEC_KIND_BIT  = 12;
  localparam int CLKOUT_BIT    = 10;
  localparam int PRI_MODE_LSB  = 8;
  localparam int TWO_SPEED_BIT = 7;
  localparam int SEC_EN_BIT    = 6;
  localparam int PLL_REF_BIT   = 4;
  localparam int INIT_LSB      = 0;
  localparam int SRC_W         = 3;
  localparam int MODE_W        = 2;
  // field position of the code-protect word
  localparam int PROTECT_BIT   = 31;

  // ==========================================================================
  // register map, byte offsets within the low address byte
  localparam int         OFS_W       = 8;
  localparam logic [7:0] OFS_OSC     = 8'h00;
  localparam logic [7:0] OFS_PROT    = 8'h04;
  localparam logic [7:0] OFS_CTRL    = 8'h08;
  localparam logic [7:0] OFS_STATUS  = 8'h0C;
  // control and status bit positions
  localparam int         CTRL_GO_BIT  = 8;
  localparam int         ST_LOAD_BIT  = 8;
  localparam int         ST_REFUSE_BIT = 9;
  localparam int         ST_PERMIT_BIT = 10;
  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [31:0] WORD_RST   = 32'hFFFFFFFF;

  // ==========================================================================
  // oscillator modes and clock sources
  typedef enum logic [1:0] {
    PRI_EXTERNAL = 2'b00,
    PRI_MEDIUM   = 2'b01,
    PRI_FAST     = 2'b10,
    PRI_OFF      = 2'b11
  } ocd_pri_t;

  typedef enum logic [2:0] {
    SRC_FRC_DIV   = 3'b000,
    SRC_PLL       = 3'b001,
    SRC_PRIMARY   = 3'b010,
    SRC_SECONDARY = 3'b100,
    SRC_SLOW_RC   = 3'b101
  } ocd_src_t;

  // decoded configuration fields
  typedef struct packed {
    logic     switch_permit;
    logic     monitor_en;
    logic     sec_crystal;
    logic     sec_ext_clk;
    logic     clkout_drive;
    ocd_pri_t pri_mode;
    logic     two_speed;
    logic     sec_osc_en;
    logic     pll_ref_frc;
    ocd_src_t init_src;
    logic     code_protect;
  } ocd_fields_t;

  // maps a raw source code onto a served source; reserved codes fall to RC
  function automatic ocd_src_t norm_src(input logic [2:0] code);
    ocd_src_t s;
    case (code)
      3'b001:  s = SRC_PLL;
      3'b010:  s = SRC_PRIMARY;
      3'b100:  s = SRC_SECONDARY;
      3'b101:  s = SRC_SLOW_RC;
      default: s = SRC_FRC_DIV;
    endcase
    return s;
  endfunction

endpackage

// ### core/ocd_cfg_if.sv
// interface carrying decoded configuration fields between design modules
`timescale 1ns/1ps
interface ocd_cfg_if;
  ocd_pkg::ocd_fields_t fields;
  modport dec (output fields);
  modport use_side (input fields);
endinterface

// ### core/ocd_decode.sv
// decoder from the two raw configuration words to control fields
`timescale 1ns/1ps
module ocd_decode (
  input  wire logic [31:0] i_osc_word,   // oscillator selection word
  input  wire logic [31:0] i_prot_word,  // code-protect word
  ocd_cfg_if.dec           cfg           // decoded fields out
);

  // field decode, pure combinational
  always_comb begin
    cfg.fields.switch_permit = i_osc_word[ocd_pkg::SWITCH_BIT];
    cfg.fields.monitor_en    = i_osc_word[ocd_pkg::MONITOR_BIT];
    cfg.fields.sec_crystal   = i_osc_word[ocd_pkg::SEC_KIND_BIT];
    cfg.fields.sec_ext_clk   = ~i_osc_word[ocd_pkg::SEC_KIND_BIT];
    cfg.fields.clkout_drive  = ~i_osc_word[ocd_pkg::CLKOUT_BIT];
    cfg.fields.pri_mode      = ocd_pkg::ocd_pri_t'(
      i_osc_word[ocd_pkg::PRI_MODE_LSB +: ocd_pkg::MODE_W]);
    cfg.fields.two_speed     = i_osc_word[ocd_pkg::TWO_SPEED_BIT];
    cfg.fields.sec_osc_en    = i_osc_word[ocd_pkg::SEC_EN_BIT];
    cfg.fields.pll_ref_frc   = i_osc_word[ocd_pkg::PLL_REF_BIT];
    cfg.fields.init_src      = ocd_pkg::norm_src(
      i_osc_word[ocd_pkg::INIT_LSB +: ocd_pkg::SRC_W]);
    cfg.fields.code_protect  = ~i_prot_word[ocd_pkg::PROTECT_BIT];
  end

endmodule

// ### core/ocd_top.sv
// oscillator configuration word latch, clock controls and register slave
`timescale 1ns/1ps
module ocd_top #(
  parameter int ADDR_W = 12                   // bus address width
) (
  input  wire logic              i_clk,           // 125 MHz clock
  input  wire logic              i_rst_n,         // async reset, low
  // configuration words from flash read-out
  input  wire logic [31:0]       i_osc_word,      // oscillator word
  input  wire logic [31:0]       i_prot_word,     // code-protect word
  input  wire logic              i_word_valid,    // words are valid
  // controls to oscillator, pll, pins and flash
  output logic                   o_cfg_loaded,    // words latched
  output logic                   o_switch_permit, // switching allowed
  output logic                   o_monitor_en,    // fail-safe monitor
  output logic                   o_sec_crystal,   // crystal owns pins
  output logic                   o_sec_ext_clk,   // external clock in
  output logic                   o_clkout_drive,  // clock onto pin
  output logic [1:0]             o_pri_mode,      // primary mode
  output logic                   o_two_speed,     // two-speed start-up
  output logic                   o_sec_osc_en,    // secondary enable
  output logic                   o_pll_ref_frc,   // pll from fast RC
  output logic [2:0]             o_osc_source,    // active source
  output logic                   o_code_protect,  // memory protected
  // axi4-lite slave
  input  wire logic [ADDR_W-1:0] i_s_axi_awaddr,  // write address
  input  wire logic              i_s_axi_awvalid, // write addr valid
  output logic                   o_s_axi_awready, // write addr ready
  input  wire logic [31:0]       i_s_axi_wdata,   // write data
  input  wire logic [3:0]        i_s_axi_wstrb,   // byte strobes
  input  wire logic              i_s_axi_wvalid,  // write data valid
  output logic                   o_s_axi_wready,  // write data ready
  output logic [1:0]             o_s_axi_bresp,   // write response
  output logic                   o_s_axi_bvalid,  // response valid
  input  wire logic              i_s_axi_bready,  // response ready
  input  wire logic [ADDR_W-1:0] i_s_axi_araddr,  // read address
  input  wire logic              i_s_axi_arvalid, // read addr valid
  output logic                   o_s_axi_arready, // read addr ready
  output logic [31:0]            o_s_axi_rdata,   // read data
  output logic [1:0]             o_s_axi_rresp,   // read response
  output logic                   o_s_axi_rvalid,  // read data valid
  input  wire logic              i_s_axi_rready   // read data ready
);

  // ==========================================================================
  // elaboration check
  generate
    if (ADDR_W <= ocd_pkg::OFS_W) begin : g_bad_addr
      $error("ocd_top: ADDR_W must exceed the offset width");
    end
  endgenerate

  // ==========================================================================
  // decode of the raw words
  ocd_cfg_if cfg_bus ();

  ocd_decode u_decode (
    .i_osc_word  (i_osc_word),
    .i_prot_word (i_prot_word),
    .cfg         (cfg_bus.dec)
  );

  // ==========================================================================
  // configuration latch state
  typedef enum logic {
    OCD_LOAD = 1'b0,
    OCD_RUN  = 1'b1
  } ocd_state_t;

  ocd_state_t           state_reg;
  ocd_state_t           state_next;
  logic [31:0]          osc_word_reg;
  logic [31:0]          osc_word_next;
  logic [31:0]          prot_word_reg;
  logic [31:0]          prot_word_next;
  ocd_pkg::ocd_fields_t fld_reg;
  ocd_pkg::ocd_fields_t fld_next;

  // capture both words exactly once after reset
  always_comb begin
    state_next     = state_reg;
    osc_word_next  = osc_word_reg;
    prot_word_next = prot_word_reg;
    fld_next       = fld_reg;
    case (state_reg)
      OCD_LOAD: begin
        if (i_word_valid) begin
          state_next     = OCD_RUN;
          osc_word_next  = i_osc_word;
          prot_word_next = i_prot_word;
          fld_next       = cfg_bus.fields;
        end
      end
      OCD_RUN:  state_next = OCD_RUN;
      default:  state_next = OCD_LOAD;
    endcase
  end

  // configuration registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_reg     <= OCD_LOAD;
      osc_word_reg  <= ocd_pkg::WORD_RST;
      prot_word_reg <= ocd_pkg::WORD_RST;
      fld_reg       <= '{default: '0, pri_mode: ocd_pkg::PRI_OFF,
                         init_src: ocd_pkg::SRC_FRC_DIV, code_protect: 1'b1};
    end else begin
      state_reg     <= state_next;
      osc_word_reg  <= osc_word_next;
      prot_word_reg <= prot_word_next;
      fld_reg       <= fld_next;
    end
  end

  // ==========================================================================
  // bus write and read decode
  logic       wr_fire;
  logic       rd_fire;
  logic       wr_hi_ok;
  logic       rd_hi_ok;
  logic [7:0] wr_ofs;
  logic [7:0] rd_ofs;
  logic       wr_ctrl;
  logic       wr_status;
  logic       wr_go;

  assign o_s_axi_awready = i_s_axi_awvalid & i_s_axi_wvalid & ~o_s_axi_bvalid;
  assign o_s_axi_wready  = o_s_axi_awready;
  assign o_s_axi_arready = ~o_s_axi_rvalid;
  assign wr_fire   = o_s_axi_awready;
  assign rd_fire   = i_s_axi_arvalid & o_s_axi_arready;
  assign wr_ofs    = i_s_axi_awaddr[ocd_pkg::OFS_W-1:0];
  assign rd_ofs    = i_s_axi_araddr[ocd_pkg::OFS_W-1:0];
  assign wr_hi_ok  = (i_s_axi_awaddr[ADDR_W-1:ocd_pkg::OFS_W] == '0);
  assign rd_hi_ok  = (i_s_axi_araddr[ADDR_W-1:ocd_pkg::OFS_W] == '0);
  assign wr_ctrl   = wr_fire & wr_hi_ok & (wr_ofs == ocd_pkg::OFS_CTRL);
  assign wr_status = wr_fire & wr_hi_ok & (wr_ofs == ocd_pkg::OFS_STATUS);
  assign wr_go     = wr_ctrl & i_s_axi_wstrb[1]
                     & i_s_axi_wdata[ocd_pkg::CTRL_GO_BIT];

  // ==========================================================================
  // active source, requested source and refusal flag
  logic [2:0]        req_src_reg;
  logic [2:0]        req_src_next;
  ocd_pkg::ocd_src_t act_src_reg;
  ocd_pkg::ocd_src_t act_src_next;
  logic              refuse_reg;
  logic              refuse_next;
  logic [2:0]        go_src;

  // source switching, gated by the latched permission
  always_comb begin
    req_src_next = req_src_reg;
    act_src_next = act_src_reg;
    refuse_next  = refuse_reg;
    go_src       = req_src_reg;
    if (wr_ctrl && i_s_axi_wstrb[0]) begin
      req_src_next = i_s_axi_wdata[ocd_pkg::SRC_W-1:0];
      go_src       = i_s_axi_wdata[ocd_pkg::SRC_W-1:0];
    end
    // clear first so that a refusal in the same cycle wins
    if (wr_status && i_s_axi_wstrb[1]
        && i_s_axi_wdata[ocd_pkg::ST_REFUSE_BIT]) begin
      refuse_next = 1'b0;
    end
    if (state_reg == OCD_LOAD && i_word_valid) begin
      act_src_next = cfg_bus.fields.init_src;
    end else if (wr_go) begin
      if (fld_reg.switch_permit && state_reg == OCD_RUN) begin
        act_src_next = ocd_pkg::norm_src(go_src);
      end else begin
        refuse_next = 1'b1;
      end
    end
  end

  // source registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      req_src_reg <= 3'h0;
      act_src_reg <= ocd_pkg::SRC_FRC_DIV;
      refuse_reg  <= 1'b0;
    end else begin
      req_src_reg <= req_src_next;
      act_src_reg <= act_src_next;
      refuse_reg  <= refuse_next;
    end
  end

  // ==========================================================================
  // bus answers
  logic        bvalid_reg;
  logic        bvalid_next;
  logic [1:0]  bresp_reg;
  logic [1:0]  bresp_next;
  logic        rvalid_reg;
  logic        rvalid_next;
  logic [1:0]  rresp_reg;
  logic [1:0]  rresp_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic        wr_mapped;

  assign wr_mapped = wr_hi_ok & (wr_ofs == ocd_pkg::OFS_OSC
                     || wr_ofs == ocd_pkg::OFS_PROT
                     || wr_ofs == ocd_pkg::OFS_CTRL
                     || wr_ofs == ocd_pkg::OFS_STATUS);

  // response channels, one transfer of each kind at a time
  always_comb begin
    bvalid_next = bvalid_reg;
    bresp_next  = bresp_reg;
    rvalid_next = rvalid_reg;
    rresp_next  = rresp_reg;
    rdata_next  = rdata_reg;
    if (bvalid_reg && i_s_axi_bready) begin
      bvalid_next = 1'b0;
    end
    if (wr_fire) begin
      bvalid_next = 1'b1;
      bresp_next  = wr_mapped ? ocd_pkg::RESP_OKAY : ocd_pkg::RESP_SLVERR;
    end
    if (rvalid_reg && i_s_axi_rready) begin
      rvalid_next = 1'b0;
    end
    if (rd_fire) begin
      rvalid_next = 1'b1;
      rresp_next  = ocd_pkg::RESP_OKAY;
      rdata_next  = 32'h00000000;
      if (!rd_hi_ok) begin
        rresp_next = ocd_pkg::RESP_SLVERR;
      end else begin
        case (rd_ofs)
          ocd_pkg::OFS_OSC:  rdata_next = osc_word_reg;
          ocd_pkg::OFS_PROT: rdata_next = prot_word_reg;
          ocd_pkg::OFS_CTRL: rdata_next[ocd_pkg::SRC_W-1:0] = req_src_reg;
          ocd_pkg::OFS_STATUS: begin
            rdata_next[ocd_pkg::SRC_W-1:0]     = act_src_reg;
            rdata_next[ocd_pkg::ST_LOAD_BIT]   = (state_reg == OCD_RUN);
            rdata_next[ocd_pkg::ST_REFUSE_BIT] = refuse_reg;
            rdata_next[ocd_pkg::ST_PERMIT_BIT] = fld_reg.switch_permit;
          end
          default: rresp_next = ocd_pkg::RESP_SLVERR;
        endcase
      end
    end
  end

  // response registers
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= ocd_pkg::RESP_OKAY;
      rvalid_reg <= 1'b0;
      rresp_reg  <= ocd_pkg::RESP_OKAY;
      rdata_reg  <= 32'h00000000;
    end else begin
      bvalid_reg <= bvalid_next;
      bresp_reg  <= bresp_next;
      rvalid_reg <= rvalid_next;
      rresp_reg  <= rresp_next;
      rdata_reg  <= rdata_next;
    end
  end

  // ==========================================================================
  // outputs, all straight from registers
  assign o_s_axi_bvalid  = bvalid_reg;
  assign o_s_axi_bresp   = bresp_reg;
  assign o_s_axi_rvalid  = rvalid_reg;
  assign o_s_axi_rresp   = rresp_reg;
  assign o_s_axi_rdata   = rdata_reg;
  assign o_cfg_loaded    = (state_reg == OCD_RUN);
  assign o_switch_permit = fld_reg.switch_permit;
  assign o_monitor_en    = fld_reg.monitor_en;
  assign o_sec_crystal   = fld_reg.sec_crystal;
  assign o_sec_ext_clk   = fld_reg.sec_ext_clk;
  assign o_clkout_drive  = fld_reg.clkout_drive;
  assign o_pri_mode      = fld_reg.pri_mode;
  assign o_two_speed     = fld_reg.two_speed;
  assign o_sec_osc_en    = fld_reg.sec_osc_en;
  assign o_pll_ref_frc   = fld_reg.pll_ref_frc;
  assign o_osc_source    = act_src_reg;
  assign o_code_protect  = fld_reg.code_protect;

  // ==========================================================================
  // checks
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence load_seen;
    state_reg == OCD_LOAD && i_word_valid;
  endsequence

  sequence write_taken;
    wr_fire ##1 bvalid_reg;
  endsequence

  load_once_a: assert property (
    o_cfg_loaded |=> o_cfg_loaded && $stable(osc_word_reg))
    else $error("configuration relatched after load");
  refuse_keep_a: assert property (
    wr_go && !fld_reg.switch_permit |=> $stable(act_src_reg) && refuse_reg)
    else $error("refused switch changed the source");
  reset_src_a: assert property (
    load_seen |=> act_src_reg == ocd_pkg::norm_src(
      osc_word_reg[ocd_pkg::INIT_LSB +: ocd_pkg::SRC_W]))
    else $error("reset source differs from latched choice");
  reserved_src_a: assert property (
    o_cfg_loaded && osc_word_reg[2:1] == 2'b11 && !$past(wr_go)
    && $stable(act_src_reg) |-> fld_reg.init_src == ocd_pkg::SRC_FRC_DIV)
    else $error("reserved code not served by fast RC");
  permit_bits_a: assert property (
    o_cfg_loaded |-> o_switch_permit == osc_word_reg[ocd_pkg::SWITCH_BIT]
                     && o_monitor_en == osc_word_reg[ocd_pkg::MONITOR_BIT])
    else $error("permission bits wrong");
  pin_owner_a: assert property (
    o_cfg_loaded |-> o_sec_crystal == osc_word_reg[ocd_pkg::SEC_KIND_BIT]
                     && o_sec_ext_clk != o_sec_crystal
                     && o_clkout_drive == !osc_word_reg[ocd_pkg::CLKOUT_BIT])
    else $error("pin ownership wrong");
  osc_mode_a: assert property (
    o_cfg_loaded |-> o_pri_mode
      == osc_word_reg[ocd_pkg::PRI_MODE_LSB +: ocd_pkg::MODE_W]
      && o_two_speed == osc_word_reg[ocd_pkg::TWO_SPEED_BIT]
      && o_sec_osc_en == osc_word_reg[ocd_pkg::SEC_EN_BIT]
      && o_pll_ref_frc == osc_word_reg[ocd_pkg::PLL_REF_BIT])
    else $error("oscillator mode bits wrong");
  protect_bit_a: assert property (
    o_cfg_loaded |-> o_code_protect == !prot_word_reg[ocd_pkg::PROTECT_BIT])
    else $error("code protection wrong");
  write_resp_a: assert property (
    write_taken ##0 !i_s_axi_bready |=> o_s_axi_bvalid)
    else $error("write response dropped before ready");

endmodule

// ### verif/ocd_top_tb.sv
// self-checking testbench for the configuration word latch and decoder
`timescale 1ns/1ps
module ocd_top_tb;
  // ==========================================================================
  // stimulus and observed signals
  logic        i_clk, i_rst_n, i_word_valid;
  logic [31:0] i_osc_word, i_prot_word, i_s_axi_wdata;
  logic [11:0] i_s_axi_awaddr, i_s_axi_araddr;
  logic [3:0]  i_s_axi_wstrb;
  logic        i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready;
  logic        i_s_axi_arvalid, i_s_axi_rready;
  logic        o_cfg_loaded, o_switch_permit, o_monitor_en, o_sec_crystal;
  logic        o_sec_ext_clk, o_clkout_drive, o_two_speed, o_sec_osc_en;
  logic        o_pll_ref_frc, o_code_protect;
  logic [1:0]  o_pri_mode, o_s_axi_bresp, o_s_axi_rresp;
  logic [2:0]  o_osc_source;
  logic        o_s_axi_awready, o_s_axi_wready, o_s_axi_bvalid;
  logic        o_s_axi_arready, o_s_axi_rvalid;
  logic [31:0] o_s_axi_rdata;
  int          mismatches = 0;
  int          checked = 0;

  ocd_top #(.ADDR_W(12)) DUT (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_osc_word(i_osc_word),
    .i_prot_word(i_prot_word), .i_word_valid(i_word_valid),
    .o_cfg_loaded(o_cfg_loaded), .o_switch_permit(o_switch_permit),
    .o_monitor_en(o_monitor_en), .o_sec_crystal(o_sec_crystal),
    .o_sec_ext_clk(o_sec_ext_clk), .o_clkout_drive(o_clkout_drive),
    .o_pri_mode(o_pri_mode), .o_two_speed(o_two_speed),
    .o_sec_osc_en(o_sec_osc_en), .o_pll_ref_frc(o_pll_ref_frc),
    .o_osc_source(o_osc_source), .o_code_protect(o_code_protect),
    .i_s_axi_awaddr(i_s_axi_awaddr), .i_s_axi_awvalid(i_s_axi_awvalid),
    .o_s_axi_awready(o_s_axi_awready), .i_s_axi_wdata(i_s_axi_wdata),
    .i_s_axi_wstrb(i_s_axi_wstrb), .i_s_axi_wvalid(i_s_axi_wvalid),
    .o_s_axi_wready(o_s_axi_wready), .o_s_axi_bresp(o_s_axi_bresp),
    .o_s_axi_bvalid(o_s_axi_bvalid), .i_s_axi_bready(i_s_axi_bready),
    .i_s_axi_araddr(i_s_axi_araddr), .i_s_axi_arvalid(i_s_axi_arvalid),
    .o_s_axi_arready(o_s_axi_arready), .o_s_axi_rdata(o_s_axi_rdata),
    .o_s_axi_rresp(o_s_axi_rresp), .o_s_axi_rvalid(o_s_axi_rvalid),
    .i_s_axi_rready(i_s_axi_rready));

  // 125 MHz clock
  initial i_clk = 1'b0;
  always #4 i_clk = ~i_clk;

  // ==========================================================================
  // helpers
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_done;
    if (mismatches == 0 && checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // word with every reserved position programmed to one
  function automatic logic [31:0] osc_word(input logic [2:0] i);
    return 32'hFFFF2828 | {16'h0, i[0], i[1], 1'b0, i[2], 1'b0,
      i[1] ^ i[0], i[1:0], i[2] ^ i[0], ~i[2], 1'b0, i[1] ^ i[2], 1'b0, i};
  endfunction

  // served source after reserved codes fall back to divided fast RC
  function automatic logic [2:0] exp_src(input logic [2:0] c);
    case (c)
      3'h1, 3'h2, 3'h4, 3'h5: return c;
      default: return 3'h0;
    endcase
  endfunction

  // write: address and data offered together, held until taken
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d,
                        input logic [3:0] s, output logic [1:0] r);
    @(posedge i_clk);
    i_s_axi_awaddr <= a;
    i_s_axi_wdata <= d;
    i_s_axi_wstrb <= s;
    i_s_axi_awvalid <= 1'b1;
    i_s_axi_wvalid <= 1'b1;
    do @(negedge i_clk);
    while (o_s_axi_awready !== 1'b1);
    chk("wready", o_s_axi_wready, 1'b1);
    @(posedge i_clk);
    i_s_axi_awvalid <= 1'b0;
    i_s_axi_wvalid <= 1'b0;
    do @(negedge i_clk);
    while (o_s_axi_bvalid !== 1'b1);
    // ready raised late so the response has to stand for a cycle
    @(posedge i_clk);
    i_s_axi_bready <= 1'b1;
    @(posedge i_clk);
    r = o_s_axi_bresp;
    i_s_axi_bready <= 1'b0;
  endtask

  // read: address held until taken, data taken at the rvalid edge
  task automatic axi_rd(input logic [11:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    @(posedge i_clk);
    i_s_axi_araddr <= a;
    i_s_axi_arvalid <= 1'b1;
    i_s_axi_rready <= 1'b1;
    do @(negedge i_clk);
    while (o_s_axi_arready !== 1'b1);
    @(posedge i_clk);
    i_s_axi_arvalid <= 1'b0;
    do @(negedge i_clk);
    while (o_s_axi_rvalid !== 1'b1);
    chk("arready", o_s_axi_arready, 1'b0);
    d = o_s_axi_rdata;
    r = o_s_axi_rresp;
    @(posedge i_clk);
    i_s_axi_rready <= 1'b0;
  endtask

  // reset for 4 cycles, then offer both words and check every control
  task automatic load(input logic [31:0] ow, input logic [31:0] pw);
    @(posedge i_clk);
    i_rst_n <= 1'b0;
    i_word_valid <= 1'b0;
    repeat (4) @(posedge i_clk);
    i_rst_n <= 1'b1;
    @(posedge i_clk);
    i_osc_word <= ow;
    i_prot_word <= pw;
    i_word_valid <= 1'b1;
    repeat (2) @(posedge i_clk);
    @(negedge i_clk);
    chk("loaded", o_cfg_loaded, 1'b1);
    chk("switch", o_switch_permit, ow[15]);
    chk("monitor", o_monitor_en, ow[14]);
    chk("crystal", o_sec_crystal, ow[12]);
    chk("ext_clk", o_sec_ext_clk, !ow[12]);
    chk("clkout", o_clkout_drive, !ow[10]);
    chk("pri_mode", o_pri_mode, ow[9:8]);
    chk("two_speed", o_two_speed, ow[7]);
    chk("sec_en", o_sec_osc_en, ow[6]);
    chk("pll_ref", o_pll_ref_frc, ow[4]);
    chk("source", o_osc_source, exp_src(ow[2:0]));
    chk("protect", o_code_protect, !pw[31]);
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_reset;
    logic [31:0] d;
    logic [1:0]  r;
    @(negedge i_clk);
    chk("rst_src", o_osc_source, 3'h0);
    chk("rst_mode", o_pri_mode, 2'h3);
    chk("rst_prot", o_code_protect, 1'b1);
    chk("rst_load", o_cfg_loaded, 1'b0);
    @(posedge i_clk);
    i_rst_n <= 1'b1;
    axi_rd(12'h000, d, r);
    chk("unloaded_rd", d, 32'hFFFFFFFF);
  endtask

  // all source codes, all modes, every decoded bit in both levels
  task automatic t_decode;
    for (int i = 0; i < 8; i++)
      load(osc_word(i[2:0]), {i[0], 31'h7FFFFFFF});
  endtask

  // later word changes ignored; raw word and status read back
  task automatic t_hold;
    logic [31:0] d;
    logic [1:0]  r;
    load(osc_word(3'h5), 32'h7FFFFFFF);
    @(posedge i_clk);
    i_osc_word <= 32'h0;
    i_prot_word <= 32'hFFFFFFFF;
    repeat (3) @(posedge i_clk);
    @(negedge i_clk);
    chk("hold_src", o_osc_source, 3'h5);
    chk("hold_prot", o_code_protect, 1'b1);
    axi_wr(12'h000, 32'h0, 4'hF, r);
    chk("ro_resp", r, 2'h0);
    axi_rd(12'h000, d, r);
    chk("osc_rd", d, osc_word(3'h5));
    axi_rd(12'h00C, d, r);
    chk("status", d, 32'h00000505);
  endtask

  // switching permitted: every requested code, reserved ones to RC
  task automatic t_switch;
    logic [1:0] r;
    load(osc_word(3'h1), 32'hFFFFFFFF);
    for (int c = 7; c >= 0; c--) begin
      axi_wr(12'h008, {23'h0, 1'b1, 5'h0, c[2:0]}, 4'h3, r);
      @(negedge i_clk);
      chk("sw_src", o_osc_source, exp_src(c[2:0]));
    end
  endtask

  // switching not permitted: refused, sticky, cleared by writing one
  task automatic t_refuse;
    logic [31:0] d;
    logic [1:0]  r;
    load(osc_word(3'h2), 32'hFFFFFFFF);
    axi_wr(12'h008, 32'h00000104, 4'h3, r);
    repeat (2) @(negedge i_clk);
    chk("ref_src", o_osc_source, 3'h2);
    axi_rd(12'h00C, d, r);
    chk("ref_flag", d[9], 1'b1);
    axi_wr(12'h00C, 32'h00000200, 4'h2, r);
    axi_rd(12'h00C, d, r);
    chk("ref_clr", d[9], 1'b0);
  endtask

  // unmapped offsets and upper address bits answer with an error
  task automatic t_unmapped;
    logic [31:0] d;
    logic [1:0]  r;
    axi_wr(12'h010, 32'h0, 4'hF, r);
    chk("un_wr", r, ocd_pkg::RESP_SLVERR);
    axi_rd(12'h010, d, r);
    chk("un_rd", r, ocd_pkg::RESP_SLVERR);
    chk("un_data", d, 32'h0);
    axi_rd(12'h104, d, r);
    chk("hi_rd", r, ocd_pkg::RESP_SLVERR);
  endtask

  // ==========================================================================
  // main sequence and watchdog
  initial begin
    i_rst_n = 1'b0;
    i_word_valid = 1'b0;
    i_osc_word = 32'h0;
    i_prot_word = 32'h0;
    {i_s_axi_awaddr, i_s_axi_araddr} = 24'h0;
    i_s_axi_wdata = 32'h0;
    i_s_axi_wstrb = 4'h0;
    {i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready} = 3'h0;
    {i_s_axi_arvalid, i_s_axi_rready} = 2'h0;
    repeat (4) @(posedge i_clk);
    t_reset;
    t_decode;
    t_hold;
    t_switch;
    t_refuse;
    t_unmapped;
    test_done;
  end

  initial begin
    repeat (20000) @(posedge i_clk);
    mismatches++;
    test_done;
  end
endmodule
